// ### fault_code_pkg.sv
// Package with fault codes, sequence states and blink timing for the fault classifier
//
// Operation
// - Line noise, frequency or dropout raises 1-2
// - Flame in standby or purge raises 2-1
// - Flame missing after pilot, lost later: 2-2
// - Flame signal over valid range raises 2-3
// - Lockout interlock on when improper raises 3-2
// - Proving switch in wrong state raises 3-3
// - Purge card missing or changed raises 4-1
// - Output on when it should be off: 4-2
// - Amplifier flame indication disagrees raises 4-3
// - LED shows tens fast, then units slow
// - Pattern repeats until reset button pressed
package fault_code_pkg;

    // ****************************************
    // Sequence states reported by the sequencer
    // ****************************************
    localparam int SEQ_W = 3;
    localparam logic [SEQ_W-1:0] SEQ_STANDBY = 3'h0;
    localparam logic [SEQ_W-1:0] SEQ_PREPURGE = 3'h1;
    localparam logic [SEQ_W-1:0] SEQ_PILOT = 3'h2;
    localparam logic [SEQ_W-1:0] SEQ_MAIN = 3'h3;
    localparam logic [SEQ_W-1:0] SEQ_RUN = 3'h4;
    localparam logic [SEQ_W-1:0] SEQ_POSTPURGE = 3'h5;

    // ****************************************
    // Fault codes, tens digit in high nibble
    // ****************************************
    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_AC = 8'h12;
    localparam logic [7:0] CODE_FLAME_UNEXP = 8'h21;
    localparam logic [7:0] CODE_FLAME_ABSENT = 8'h22;
    localparam logic [7:0] CODE_FLAME_OVER = 8'h23;
    localparam logic [7:0] CODE_INTLK_PURGE = 8'h31;
    localparam logic [7:0] CODE_INTLK_IMPROPER = 8'h32;
    localparam logic [7:0] CODE_PROVING = 8'h33;
    localparam logic [7:0] CODE_PURGE_CARD = 8'h41;
    localparam logic [7:0] CODE_OUTPUT_ON = 8'h42;
    localparam logic [7:0] CODE_AMPLIFIER = 8'h43;

    // ****************************************
    // Flame signal limit and blink timing
    // ****************************************
    localparam int FLAME_W = 8;
    localparam logic [FLAME_W-1:0] FLAME_MAX = 8'he6;
    localparam int CLK_HZ = 40000000;
    localparam int FAST_MS = 100;
    localparam int SLOW_MS = 500;
    localparam int GAP_MS = 2000;
    localparam int FAST_CYC = CLK_HZ / 1000 * FAST_MS;
    localparam int SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
    localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
    localparam int CNT_W = 27;
    localparam int PURGE_W = 4;

endpackage

// ### sync3.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Pin side
    input wire logic [W-1:0] async,
    // Synchronised side
    output logic [W-1:0] syncd
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } sync_t;

    sync_t st_q;
    sync_t st_d;

    // Shift and accept only when stages two and three agree
    always_comb begin
        st_d = st_q;
        st_d.s1 = async;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    // Register stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign syncd = st_q.out;
endmodule
`default_nettype wire

// ### fault_classifier.sv
// Burner fault detection, code selection, blink display and interrupt
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fault_classifier (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Sequencer state, same clock domain
    input wire logic [2:0] seqState,
    input wire logic pilotEnd,
    input wire logic provingActive,
    input wire logic provingExpect,
    input wire logic lockoutAllowed,
    input wire logic pilotReq,
    input wire logic upstreamReq,
    input wire logic ignitionReq,
    input wire logic downstreamReq,
    // Field pins, asynchronous
    input wire logic flameIn,
    input wire logic ampFlame,
    input wire logic runIntlkFault,
    input wire logic lockIntlkIn,
    input wire logic valve_proving_switch,
    input wire logic pilotFb,
    input wire logic upstreamFb,
    input wire logic ignitionFb,
    input wire logic downstreamFb,
    input wire logic lineNoise,
    input wire logic lineFreqBad,
    input wire logic lineDropout,
    input wire logic cardPresent,
    input wire logic [3:0] cardTiming,
    input wire logic resetButton,
    // Flame signal value, same clock domain
    input wire logic [7:0] flameValue,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Annunciation
    output logic powerLed,
    output logic lockout,
    output logic [7:0] faultCode,
    output logic irq
);
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] REG_CODE = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_MASK = 4'h8;
    localparam logic [3:0] REG_CTRL = 4'hc;
    localparam int NEV = 10;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    localparam int PW = 18;
    logic [PW-1:0] pinRaw;
    logic [PW-1:0] pinS;
    assign pinRaw = {flameIn, ampFlame, runIntlkFault, lockIntlkIn, valve_proving_switch,
                     pilotFb, upstreamFb, ignitionFb, downstreamFb, lineNoise, lineFreqBad,
                     lineDropout, cardPresent, cardTiming, resetButton};

    sync3 #(.W(PW)) pinSync (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .async(pinRaw),
        .syncd(pinS)
    );

    // Named views of synchronised pins
    logic fFlame, fAmp, fRun, fLock, fProve, fbPilot, fbUp, fbIgn, fbDown;
    logic fNoise, fFreq, fDrop, fCard, fReset;
    logic [3:0] fTiming;
    assign {fFlame, fAmp, fRun, fLock, fProve, fbPilot, fbUp, fbIgn, fbDown,
            fNoise, fFreq, fDrop, fCard, fTiming, fReset} = pinS;

    // ****************************************
    // Display states and module state
    // ****************************************
    typedef enum logic [2:0] {
        D_IDLE,
        D_TENS_ON,
        D_TENS_OFF,
        D_UNITS_ON,
        D_UNITS_OFF,
        D_GAP
    } disp_t;

    typedef struct packed {
        logic locked;          // Latched safety shutdown
        logic [7:0] code;      // Selected fault code
        disp_t disp;           // Blink phase
        logic [26:0] timer;    // Phase timer
        logic [3:0] blinks;    // Blinks left in current digit
        logic led;             // LED drive
        logic cardSeen;        // Timing captured
        logic [3:0] cardRef;   // Captured card timing
        logic prevFlame;       // Flame seen last cycle
        logic prevReset;       // Reset button last cycle
        logic [2:0] warm;      // Pins read zero until the sync fills
        logic [NEV-1:0] status;
        logic [NEV-1:0] mask;
        logic detectEn;        // Software enable of detection
        logic [31:0] rdata;
    } state_t;

    state_t st_q;
    state_t st_d;

    // ****************************************
    // Fault detection
    // ****************************************
    logic [NEV-1:0] ev;
    logic inPurge;
    logic flameExpected;
    assign inPurge = (seqState == fault_code_pkg::SEQ_PREPURGE) ||
                     (seqState == fault_code_pkg::SEQ_POSTPURGE);
    assign flameExpected = (seqState == fault_code_pkg::SEQ_MAIN) ||
                           (seqState == fault_code_pkg::SEQ_RUN) ||
                           ((seqState == fault_code_pkg::SEQ_PILOT) && pilotEnd);

    always_comb begin
        ev = '0;
        ev[0] = fNoise | fFreq | fDrop;
        ev[1] = fFlame & ((seqState == fault_code_pkg::SEQ_STANDBY) | inPurge);
        // No flame at pilot end, or a later falling edge
        ev[2] = ((seqState == fault_code_pkg::SEQ_PILOT) & pilotEnd & ~fFlame) |
                (((seqState == fault_code_pkg::SEQ_MAIN) |
                  (seqState == fault_code_pkg::SEQ_RUN)) & st_q.prevFlame & ~fFlame);
        ev[3] = flameValue > fault_code_pkg::FLAME_MAX;
        ev[4] = (seqState == fault_code_pkg::SEQ_PREPURGE) & fRun;
        ev[5] = fLock & ~lockoutAllowed;
        ev[6] = provingActive & (fProve != provingExpect);
        ev[7] = ~fCard | (st_q.cardSeen & (fTiming != st_q.cardRef));
        ev[8] = (fbPilot & ~pilotReq) | (fbUp & ~upstreamReq) |
                (fbIgn & ~ignitionReq) | (fbDown & ~downstreamReq);
        ev[9] = (fAmp != flameExpected) &
                (seqState != fault_code_pkg::SEQ_PILOT | pilotEnd);
    end

    // Priority select; lowest code wins
    function automatic logic [7:0] pick(input logic [NEV-1:0] e);
        logic [7:0] c;
        c = fault_code_pkg::CODE_NONE;
        if (e[0]) c = fault_code_pkg::CODE_AC;
        else if (e[1]) c = fault_code_pkg::CODE_FLAME_UNEXP;
        else if (e[2]) c = fault_code_pkg::CODE_FLAME_ABSENT;
        else if (e[3]) c = fault_code_pkg::CODE_FLAME_OVER;
        else if (e[4]) c = fault_code_pkg::CODE_INTLK_PURGE;
        else if (e[5]) c = fault_code_pkg::CODE_INTLK_IMPROPER;
        else if (e[6]) c = fault_code_pkg::CODE_PROVING;
        else if (e[7]) c = fault_code_pkg::CODE_PURGE_CARD;
        else if (e[8]) c = fault_code_pkg::CODE_OUTPUT_ON;
        else if (e[9]) c = fault_code_pkg::CODE_AMPLIFIER;
        return c;
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************
    logic [NEV-1:0] evGated;
    logic pressEdge;
    assign evGated = (st_q.detectEn && st_q.warm == 3'h4) ? ev : '0;
    assign pressEdge = fReset & ~st_q.prevReset;

    always_comb begin
        st_d = st_q;
        st_d.prevFlame = fFlame;
        st_d.prevReset = fReset;
        st_d.rdata = '0;
        if (st_q.warm != 3'h4) st_d.warm = st_q.warm + 3'h1;

        // Capture card timing on first sight
        if (!st_q.cardSeen && fCard) begin
            st_d.cardSeen = 1'b1;
            st_d.cardRef = fTiming;
        end

        // Latch first fault; only the button clears it
        if (st_q.locked) begin
            if (pressEdge) begin
                st_d.locked = 1'b0;
                st_d.code = fault_code_pkg::CODE_NONE;
                st_d.disp = D_IDLE;
                st_d.led = 1'b1;
                st_d.cardSeen = 1'b0;
            end
        end else if (evGated != '0) begin
            st_d.locked = 1'b1;
            st_d.code = pick(evGated);
            st_d.disp = D_GAP;
            st_d.timer = '0;
            st_d.led = 1'b0;
        end

        // Blink sequencer, LED steady on while healthy
        if (st_q.locked && !pressEdge) begin
            st_d.timer = st_q.timer + 27'h1;
            case (st_q.disp)
                D_GAP: begin
                    st_d.led = 1'b0;
                    if (st_q.timer >= 27'(fault_code_pkg::GAP_CYC - 1)) begin
                        st_d.disp = D_TENS_ON;
                        st_d.timer = '0;
                        st_d.blinks = st_q.code[7:4];
                        st_d.led = 1'b1;
                    end
                end
                D_TENS_ON: begin
                    if (st_q.timer >= 27'(fault_code_pkg::FAST_CYC - 1)) begin
                        st_d.disp = D_TENS_OFF;
                        st_d.timer = '0;
                        st_d.led = 1'b0;
                        st_d.blinks = st_q.blinks - 4'h1;
                    end
                end
                D_TENS_OFF: begin
                    if (st_q.timer >= 27'(fault_code_pkg::FAST_CYC - 1)) begin
                        st_d.timer = '0;
                        st_d.led = 1'b1;
                        if (st_q.blinks != 4'h0) begin
                            st_d.disp = D_TENS_ON;
                        end else begin
                            st_d.disp = D_UNITS_ON;
                            st_d.blinks = st_q.code[3:0];
                        end
                    end
                end
                D_UNITS_ON: begin
                    if (st_q.timer >= 27'(fault_code_pkg::SLOW_CYC - 1)) begin
                        st_d.disp = D_UNITS_OFF;
                        st_d.timer = '0;
                        st_d.led = 1'b0;
                        st_d.blinks = st_q.blinks - 4'h1;
                    end
                end
                D_UNITS_OFF: begin
                    if (st_q.timer >= 27'(fault_code_pkg::SLOW_CYC - 1)) begin
                        st_d.timer = '0;
                        if (st_q.blinks != 4'h0) begin
                            st_d.disp = D_UNITS_ON;
                            st_d.led = 1'b1;
                        end else begin
                            st_d.disp = D_GAP;
                        end
                    end
                end
                default: begin
                    st_d.disp = D_GAP;
                    st_d.timer = '0;
                end
            endcase
        end

        // Register writes; status clears by writing one, set wins
        if (regWr) begin
            case (regAddr)
                REG_MASK: st_d.mask = regWdata[NEV-1:0];
                REG_CTRL: st_d.detectEn = regWdata[0];
                REG_STATUS: st_d.status = st_q.status & ~regWdata[NEV-1:0];
                default: ;
            endcase
        end
        st_d.status = st_d.status | evGated;

        // Register reads, answered next cycle; unmapped reads zero
        if (regRd) begin
            case (regAddr)
                REG_CODE: st_d.rdata = {23'h0, st_q.locked, st_q.code};
                REG_STATUS: st_d.rdata = {22'h0, st_q.status};
                REG_MASK: st_d.rdata = {22'h0, st_q.mask};
                REG_CTRL: st_d.rdata = {31'h0, st_q.detectEn};
                default: st_d.rdata = '0;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q <= '0;
            st_q.disp <= D_IDLE;
            st_q.led <= 1'b1;
            st_q.detectEn <= 1'b1;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign regRdata = st_q.rdata;
    assign powerLed = st_q.led;
    assign lockout = st_q.locked;
    assign faultCode = st_q.code;
    assign irq = |(st_q.status & ~st_q.mask);
endmodule
`default_nettype wire

// ### burner_field_model.sv
// Field side model: flame, interlocks, proving switch, valve feedback, purge card
`timescale 1ns/1ps
`default_nettype none
module burner_field_model #(
    parameter logic [3:0] CARD_T = 4'h5 // Nominal card timing, value is arbitrary
) (
    // Scenario knobs from the bench
    input wire logic flameOn,
    input wire logic ampBad,
    input wire logic runIntlk,
    input wire logic lockIntlk,
    input wire logic proveSw,
    input wire logic [3:0] stuck,
    input wire logic cardOut,
    input wire logic cardShift,
    // Valve and ignition commands
    input wire logic [3:0] req,
    // Field pins
    output logic flameIn,
    output logic ampFlame,
    output logic runIntlkFault,
    output logic lockIntlkIn,
    output logic provSw,
    output logic [3:0] fb,
    output logic cardPresent,
    output logic [3:0] cardTiming
);
    // ************************
    // Pin levels
    // ************************
    // Amplifier agrees with the detector unless a scenario breaks it
    assign flameIn = flameOn;
    assign ampFlame = flameOn ^ ampBad;
    assign runIntlkFault = runIntlk;
    assign lockIntlkIn = lockIntlk;
    assign provSw = proveSw;
    // A welded contact keeps feedback up after the command drops
    assign fb = req | stuck;
    // Pulled or swapped card at the connector
    assign cardPresent = ~cardOut;
    assign cardTiming = cardShift ? ~CARD_T : CARD_T;
endmodule
`default_nettype wire

// ### fault_classifier_assertions.sv
// Checker of fault latch, LED and register port behaviour
`timescale 1ns/1ps
`default_nettype none
module fault_classifier_assertions (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // Watched inputs
    input wire logic resetButton,
    input wire logic lineNoise,
    input wire logic [7:0] flameValue,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    // Watched outputs
    input wire logic [31:0] regRdata,
    input wire logic powerLed,
    input wire logic lockout,
    input wire logic [7:0] faultCode,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst || !ce);
    // ************************
    // Helper state
    // ************************
    logic enQ; // Mirror of detect enable
    logic [3:0] ageQ; // Cycles since button seen, saturates
    always_ff @(posedge mclk) begin
        if (srst) begin
            enQ <= 1'b1;
            ageQ <= 4'hf;
        end else if (ce) begin
            if (regWr && regAddr == 4'hc) begin
                enQ <= regWdata[0];
            end
            ageQ <= resetButton ? 4'h0 : ((ageQ == 4'hf) ? ageQ : ageQ + 4'h1);
        end
    end
    led_steady_a: assert property (!lockout && !$past(lockout) && !$past(lockout, 2) |-> powerLed)
        else $error("LED dark with no fault");
    led_gap_a: assert property ($rose(lockout) |=> !powerLed [*8])
        else $error("LED lit right after lock");
    code_hold_a: assert property (lockout && $past(lockout) |-> $stable(faultCode))
        else $error("Code changed while locked");
    code_valid_a: assert property (lockout |-> faultCode inside {8'h12, 8'h21, 8'h22, 8'h23,
        8'h31, 8'h32, 8'h33, 8'h41, 8'h42, 8'h43}) else $error("Locked with unknown code");
    clear_btn_a: assert property ($fell(lockout) |-> ageQ < 4'h8)
        else $error("Latch released without button");
    over_lock_a: assert property (enQ && !lockout && flameValue > fault_code_pkg::FLAME_MAX
        |-> ##[1:4] lockout) else $error("Overrange flame not latched");
    line_lock_a: assert property ($rose(lineNoise) && enQ && !lockout ##1 lineNoise [*4]
        |-> ##[0:3] lockout && faultCode == 8'h12) else $error("Line fault not latched");
    rd_code_a: assert property (regRd && regAddr == 4'h0 |=>
        regRdata == {23'h0, $past(lockout), $past(faultCode)}) else $error("Code read wrong");
    rd_idle_a: assert property (!regRd |=> regRdata == 32'h0)
        else $error("Read data outside read slot");
    rd_unmapped_a: assert property (regRd && regAddr[1:0] != 2'h0 |=> regRdata == 32'h0)
        else $error("Unmapped read not zero");
    cover property ($rose(lockout));
    cover property ($fell(lockout));
    cover property ($rose(irq));
endmodule
bind fault_classifier fault_classifier_assertions checker_i (.mclk(mclk), .srst(srst), .ce(ce),
    .resetButton(resetButton), .lineNoise(lineNoise), .flameValue(flameValue), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .powerLed(powerLed),
    .lockout(lockout), .faultCode(faultCode), .irq(irq));
`default_nettype wire

// ### fault_classifier_tb.sv
// Self-checking bench for the burner fault classifier
`timescale 1ns/1ps
`default_nettype none
module fault_classifier_tb;
    // ************************
    // Stimulus in one word, so rest is one assignment
    // ************************
    typedef struct packed {
        logic [2:0] seqState;
        logic pilotEnd, provingActive, provingExpect, lockoutAllowed;
        logic [3:0] req, stuck;
        logic flameOn, ampBad, runIntlk, lockIntlk, proveSw, cardOut, cardShift;
        logic [2:0] lineBad;
        logic [7:0] flameValue;
    } knob_t;
    knob_t k = '0;
    logic mclk = 1'b0, srst = 1'b1, resetButton = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [3:0] regAddr = 4'h0, fb, cardTiming;
    logic [31:0] regWdata = 32'h0, regRdata, rdv;
    logic flameIn, ampFlame, runIntlkFault, lockIntlkIn, provSw, cardPresent, powerLed, lockout, irq;
    logic [7:0] faultCode;
    int errors = 0, testsRun = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    burner_field_model FIELD (.flameOn(k.flameOn), .ampBad(k.ampBad), .runIntlk(k.runIntlk),
        .lockIntlk(k.lockIntlk), .proveSw(k.proveSw), .stuck(k.stuck), .cardOut(k.cardOut),
        .cardShift(k.cardShift), .req(k.req), .flameIn(flameIn), .ampFlame(ampFlame),
        .runIntlkFault(runIntlkFault), .lockIntlkIn(lockIntlkIn), .provSw(provSw), .fb(fb),
        .cardPresent(cardPresent), .cardTiming(cardTiming));
    fault_classifier DUT (.mclk(mclk), .srst(srst), .ce(1'b1), .seqState(k.seqState),
        .pilotEnd(k.pilotEnd), .provingActive(k.provingActive), .provingExpect(k.provingExpect),
        .lockoutAllowed(k.lockoutAllowed), .pilotReq(k.req[0]), .upstreamReq(k.req[1]),
        .ignitionReq(k.req[2]), .downstreamReq(k.req[3]), .flameIn(flameIn), .ampFlame(ampFlame),
        .runIntlkFault(runIntlkFault), .lockIntlkIn(lockIntlkIn), .valve_proving_switch(provSw),
        .pilotFb(fb[0]), .upstreamFb(fb[1]), .ignitionFb(fb[2]), .downstreamFb(fb[3]),
        .lineNoise(k.lineBad[0]), .lineFreqBad(k.lineBad[1]), .lineDropout(k.lineBad[2]),
        .cardPresent(cardPresent), .cardTiming(cardTiming), .resetButton(resetButton),
        .flameValue(k.flameValue), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .powerLed(powerLed), .lockout(lockout),
        .faultCode(faultCode), .irq(irq));
    // ************************
    // Shared tasks
    // ************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask
    task automatic quiet(input int n);
        cycles(n);
        #1 chk(32'(lockout), 32'h0);
    endtask
    // Wait for the latch, then code, LED, register copy, status bit and interrupt
    task automatic lockCheck(input logic [7:0] code, input int b);
        for (int n = 0; n < 12 && lockout !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk(32'(faultCode), 32'(code));
        cycles(20);
        #1 chk(32'(faultCode), 32'(code));
        chk(32'(powerLed), 32'h0);
        chk(32'(irq), 32'h1);
        rd(4'h0);
        chk(rdv, {23'h0, 1'b1, code});
        rd(4'h4);
        chk(32'(rdv[b]), 32'h1);
    endtask
    // Field to rest first, so the button meets no live fault
    task automatic clearFault;
        @(posedge mclk);
        k <= '0;
        cycles(8);
        resetButton <= 1'b1;
        cycles(5);
        resetButton <= 1'b0;
        cycles(10);
        #1 chk(32'(powerLed), 32'h1);
        wr(4'h4, 32'h3ff);
        rd(4'h4);
        chk(rdv, 32'h0);
        chk(32'(irq), 32'h0);
    endtask
    // ************************
    // Scenarios
    // ************************
    task automatic tOver;
        rd(4'hc);
        chk(rdv, 32'h1);
        @(posedge mclk);
        k.flameValue <= 8'he6;
        quiet(10);
        @(posedge mclk);
        k.flameValue <= 8'he7;
        lockCheck(8'h23, 3);
        wr(4'h8, 32'h3ff);
        rd(4'h8);
        chk(rdv, 32'h3ff);
        chk(32'(irq), 32'h0);
        wr(4'h8, 32'h0);
        rd(4'h2);
        chk(rdv, 32'h0);
        chk(32'(irq), 32'h1);
        clearFault();
        $display("overrange test done");
    endtask
    task automatic tLine;
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            k.lineBad <= 3'(1 << i);
            lockCheck(8'h12, 0);
            clearFault();
        end
        $display("line quality test done");
    endtask
    task automatic tUnexp;
        for (int s = 0; s < 2; s++) begin
            @(posedge mclk);
            k.seqState <= 3'(s);
            k.lockoutAllowed <= 1'b1;
            k.lockIntlk <= 1'b1;
            k.flameOn <= 1'b1;
            lockCheck(8'h21, 1);
            clearFault();
        end
        $display("unexpected flame test done");
    endtask
    task automatic tAbsent;
        @(posedge mclk);
        k.seqState <= 3'h2;
        k.pilotEnd <= 1'b1;
        lockCheck(8'h22, 2);
        clearFault();
        @(posedge mclk);
        k.seqState <= 3'h2;
        k.flameOn <= 1'b1;
        quiet(10);
        @(posedge mclk);
        k.seqState <= 3'h4;
        quiet(10);
        @(posedge mclk);
        k.flameOn <= 1'b0;
        lockCheck(8'h22, 2);
        clearFault();
        $display("flame loss test done");
    endtask
    task automatic tAmp;
        @(posedge mclk);
        k.seqState <= 3'h2;
        k.flameOn <= 1'b1;
        cycles(8);
        k.pilotEnd <= 1'b1;
        quiet(10);
        @(posedge mclk);
        k.ampBad <= 1'b1;
        lockCheck(8'h43, 9);
        clearFault();
        $display("amplifier test done");
    endtask
    task automatic tInterlock;
        @(posedge mclk);
        k.seqState <= 3'h1;
        k.lockoutAllowed <= 1'b1;
        k.lockIntlk <= 1'b1;
        quiet(10);
        @(posedge mclk);
        k.runIntlk <= 1'b1;
        lockCheck(8'h31, 4);
        clearFault();
        @(posedge mclk);
        k.lockIntlk <= 1'b1;
        lockCheck(8'h32, 5);
        clearFault();
        $display("interlock test done");
    endtask
    task automatic tProve;
        @(posedge mclk);
        k.proveSw <= 1'b1;
        cycles(6);
        k.provingActive <= 1'b1;
        k.provingExpect <= 1'b1;
        quiet(10);
        @(posedge mclk);
        k.proveSw <= 1'b0;
        lockCheck(8'h33, 6);
        clearFault();
        $display("proving switch test done");
    endtask
    task automatic tCard;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            k.cardShift <= (i == 0);
            k.cardOut <= (i == 1);
            lockCheck(8'h41, 7);
            clearFault();
        end
        $display("purge card test done");
    endtask
    task automatic tOutput;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            k.req <= 4'(1 << i);
            k.stuck <= 4'(1 << i);
            quiet(10);
            @(posedge mclk);
            k.req <= 4'h0;
            lockCheck(8'h42, 8);
            clearFault();
        end
        $display("output feedback test done");
    endtask
    // ************************
    // Run control
    // ************************
    task automatic finishTest;
        $display("checks %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Ceiling far above the run's length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            $display("BAD %0t run timed out", $time);
            finishTest();
        end
    end
    initial begin
        cycles(2);
        srst <= 1'b0;
        tOver();
        tLine();
        tUnexp();
        tAbsent();
        tAmp();
        tInterlock();
        tProve();
        tCard();
        tOutput();
        finishTest();
    end
endmodule
`default_nettype wire
